/* rtl/iopb_pkg.sv */
// iopb_pkg: offsets, fields, resets and types of the port-b block
package iopb_pkg;
   // ======================================================
   // register byte offsets (apb, one word each)
   localparam logic [7:0] OFS_PORT   = 8'h00;
   localparam logic [7:0] OFS_LATCH  = 8'h04;
   localparam logic [7:0] OFS_DIR    = 8'h08;
   localparam logic [7:0] OFS_ICTL2  = 8'h0C;
   localparam logic [7:0] OFS_ICTL   = 8'h10;
   localparam logic [7:0] OFS_APC    = 8'h14;
   localparam logic [7:0] OFS_STAT   = 8'h18;
   localparam logic [7:0] OFS_CLR    = 8'h1C;
   localparam logic [7:0] OFS_IEN    = 8'h20;
   localparam logic [7:0] OFS_PNOREF = 8'h24;
   // ======================================================
   // field positions
   localparam int PUD_BIT     = 7;
   localparam int CHG_BIT     = 0;
   localparam int CHG_IE_BIT  = 3;
   localparam int IOC_LO      = 4;
   localparam int ANA_PINS    = 5;
   localparam int NCHAN       = 11;
   localparam int EV_CHG      = 0;
   localparam int EV_WAKE     = 1;
   localparam int NEV         = 2;
   // ======================================================
   // reset values and thresholds
   localparam logic [7:0] DIR_RST    = 8'hFF;
   localparam logic [7:0] LATCH_RST  = 8'h00;
   localparam logic       PUD_RST    = 1'b1;
   localparam logic [3:0] SEL_ANALOG = 4'h0;
   localparam logic [3:0] SEL_DIGIT  = 4'h7;
   localparam logic [3:0] SEL_ALLANA = 4'h4;
   // ======================================================
   // types
   typedef struct packed {
      logic       neg_ext;
      logic       pos_ext;
      logic [3:0] sel;
   } iopb_apc_t;
   typedef enum logic [1:0] {
      INIT_SYNC0 = 2'b00,
      INIT_SYNC1 = 2'b01,
      INIT_SYNC2 = 2'b11,
      INIT_RUN   = 2'b10
   } iopb_init_t;
endpackage : iopb_pkg

/* rtl/iopb_port.sv */
// iopb_port: 8-bit port with direction, latch, pull-ups, change interrupt
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

module iopb_port #(
   parameter int W = 8
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic [W-1:0]  pin_in,
   output logic      [W-1:0]  pin_out,
   output logic      [W-1:0]  pin_oe,
   output logic      [W-1:0]  pullup_en,
   input  wire logic          analog_default_cfg,
   output logic      [10:0]   chan_digital,
   output logic               neg_ref_ext,
   output logic               pos_ref_ext,
   output logic               wake_req,
   output logic               irq
);

   // ======================================================
   // helpers

   // channels turned digital, counted from the top one
   function automatic logic [10:0] digital_map(input logic [3:0] sel);
      logic [3:0]  ndig;
      logic [10:0] m;
      ndig = (sel > iopb_pkg::SEL_ALLANA) ? 4'(sel - iopb_pkg::SEL_ALLANA) : 4'h0;
      m    = '0;
      for (int k = 0; k < iopb_pkg::NCHAN; k++) begin
         m[k] = (4'(iopb_pkg::NCHAN - 1 - k) < ndig);
      end
      return m;
   endfunction : digital_map

   // low five pins stay analog until select reaches 0111
   function automatic logic low_pins_analog(input logic [3:0] sel);
      return sel < iopb_pkg::SEL_DIGIT;
   endfunction : low_pins_analog

   // ======================================================
   // declarations

   logic [W-1:0]               pin_s1_q;
   logic [W-1:0]               pin_s2_q;
   logic                       strap_s1_q;
   logic                       strap_s2_q;
   iopb_pkg::iopb_init_t       init_q;
   logic [W-1:0]               dir_q;
   logic [W-1:0]               latch_q;
   logic                       pud_n_q;
   logic                       chg_flag_q;
   logic                       chg_ie_q;
   iopb_pkg::iopb_apc_t        apc_q;
   logic [3:0]                 ref_q;
   logic [iopb_pkg::NEV-1:0]   stat_q;
   logic [iopb_pkg::NEV-1:0]   ien_q;
   logic [31:0]                rdata_q;
   logic                       setup;
   logic                       acc;
   logic                       wr;
   logic                       rd;
   logic                       mapped;
   logic [W-1:0]               port_view;
   logic [3:0]                 ioc_live;
   logic                       mismatch;
   logic                       port_touch;
   logic [31:0]                rdata_d;
   logic [iopb_pkg::NEV-1:0]   ev;

   // ======================================================
   // pin and strap synchronisers

   // two flops each; only stage two is looked at
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q   <= '0;
         pin_s2_q   <= '0;
         strap_s1_q <= 1'b0;
         strap_s2_q <= 1'b0;
      end else begin
         pin_s1_q   <= pin_in;
         pin_s2_q   <= pin_s1_q;
         strap_s1_q <= analog_default_cfg;
         strap_s2_q <= strap_s1_q;
      end
   end

   // strap reaches stage two only after two edges, so it is caught at the third
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_q <= iopb_pkg::INIT_SYNC0;
      end else begin
         unique case (init_q)
            iopb_pkg::INIT_SYNC0: init_q <= iopb_pkg::INIT_SYNC1;
            iopb_pkg::INIT_SYNC1: init_q <= iopb_pkg::INIT_SYNC2;
            iopb_pkg::INIT_SYNC2: init_q <= iopb_pkg::INIT_RUN;
            iopb_pkg::INIT_RUN:   init_q <= iopb_pkg::INIT_RUN;
         endcase
      end
   end

   // ======================================================
   // apb decode

   assign setup  = psel && !penable;
   assign acc    = psel && penable;
   assign wr     = acc && pwrite;
   assign rd     = acc && !pwrite;
   assign pready = 1'b1;

   // unmapped offsets answer with an error, no side effect
   always_comb begin
      unique case (paddr)
         iopb_pkg::OFS_PORT, iopb_pkg::OFS_LATCH, iopb_pkg::OFS_DIR,
         iopb_pkg::OFS_ICTL2, iopb_pkg::OFS_ICTL, iopb_pkg::OFS_APC,
         iopb_pkg::OFS_STAT, iopb_pkg::OFS_CLR, iopb_pkg::OFS_IEN,
         iopb_pkg::OFS_PNOREF: mapped = 1'b1;
         default:              mapped = 1'b0;
      endcase
   end
   assign pslverr = acc && !mapped;

   // ======================================================
   // direction and output latch

   // all inputs at reset, so nothing drives the board
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_q <= iopb_pkg::DIR_RST;
      end else if (wr && paddr == iopb_pkg::OFS_DIR) begin
         dir_q <= pwdata[W-1:0];
      end
   end

   // port write and no-reference write both land in the latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= iopb_pkg::LATCH_RST;
      end else if (wr && (paddr == iopb_pkg::OFS_PORT ||
                          paddr == iopb_pkg::OFS_LATCH ||
                          paddr == iopb_pkg::OFS_PNOREF)) begin
         latch_q <= pwdata[W-1:0];
      end
   end

   // pins: high direction bit floats the driver
   assign pin_oe  = ~dir_q;
   assign pin_out = latch_q;

   // ======================================================
   // pull-ups

   // one shared active-low enable, reset to off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pud_n_q <= iopb_pkg::PUD_RST;
      end else if (wr && paddr == iopb_pkg::OFS_ICTL2) begin
         pud_n_q <= pwdata[iopb_pkg::PUD_BIT];
      end
   end

   // an output pin never fights its own pull-up
   assign pullup_en = {W{~pud_n_q}} & dir_q;

   // ======================================================
   // analog pin configuration

   // constant at reset; strap value loaded once it is synchronised
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apc_q <= '{neg_ext: 1'b0, pos_ext: 1'b0, sel: iopb_pkg::SEL_ANALOG};
      end else if (init_q == iopb_pkg::INIT_SYNC2) begin
         apc_q.sel <= strap_s2_q ? iopb_pkg::SEL_ANALOG
                                 : iopb_pkg::SEL_DIGIT;
      end else if (wr && paddr == iopb_pkg::OFS_APC) begin
         apc_q <= pwdata[5:0];
      end
   end

   assign chan_digital = digital_map(apc_q.sel);
   assign neg_ref_ext  = apc_q.neg_ext;
   assign pos_ref_ext  = apc_q.pos_ext;

   // analog pins read zero; digital pins show the synced level
   always_comb begin
      port_view = pin_s2_q;
      if (low_pins_analog(apc_q.sel)) begin
         port_view[iopb_pkg::ANA_PINS-1:0] = '0;
      end
   end

   // ======================================================
   // interrupt-on-change

   // top four pins, outputs masked out of the compare; nothing is judged
   // until the reference has caught up with the synced pins after reset
   assign ioc_live = pin_s2_q[W-1:iopb_pkg::IOC_LO];
   assign mismatch = (init_q == iopb_pkg::INIT_RUN) &&
                     (|((ioc_live ^ ref_q) & dir_q[W-1:iopb_pkg::IOC_LO]));

   // the no-reference offset stands for a move-file-to-file write
   assign port_touch = acc && paddr == iopb_pkg::OFS_PORT;

   // reference follows every read or write of the port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_q <= '0;
      end else if (init_q != iopb_pkg::INIT_RUN) begin
         ref_q <= ioc_live; // avoids a false change right after reset
      end else if (port_touch) begin
         ref_q <= ioc_live;
      end
   end

   // flag set while mismatch stands; set beats a clearing write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chg_flag_q <= 1'b0;
         chg_ie_q   <= 1'b0;
      end else begin
         if (wr && paddr == iopb_pkg::OFS_ICTL) begin
            chg_flag_q <= pwdata[iopb_pkg::CHG_BIT];
            chg_ie_q   <= pwdata[iopb_pkg::CHG_IE_BIT];
         end
         if (mismatch) begin
            chg_flag_q <= 1'b1;
         end
      end
   end

   // wake from sleep is a level while an enabled change is flagged
   assign wake_req = chg_flag_q && chg_ie_q;

   // ======================================================
   // event status, enable and interrupt

   assign ev[iopb_pkg::EV_CHG]  = mismatch;
   assign ev[iopb_pkg::EV_WAKE] = wake_req;

   // sticky status; write-one-to-clear loses to a new event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
      end else if (wr && paddr == iopb_pkg::OFS_CLR) begin
         stat_q <= (stat_q & ~pwdata[iopb_pkg::NEV-1:0]) | ev;
      end else begin
         stat_q <= stat_q | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ien_q <= '0;
      end else if (wr && paddr == iopb_pkg::OFS_IEN) begin
         ien_q <= pwdata[iopb_pkg::NEV-1:0];
      end
   end

   assign irq = |(stat_q & ien_q);

   // ======================================================
   // read data

   // captured in setup so the access phase needs no wait state
   always_comb begin
      rdata_d = '0;
      unique case (paddr)
         iopb_pkg::OFS_PORT:   rdata_d[W-1:0] = port_view;
         iopb_pkg::OFS_LATCH:  rdata_d[W-1:0] = latch_q;
         iopb_pkg::OFS_DIR:    rdata_d[W-1:0] = dir_q;
         iopb_pkg::OFS_ICTL2:  rdata_d[iopb_pkg::PUD_BIT] = pud_n_q;
         iopb_pkg::OFS_ICTL: begin
            rdata_d[iopb_pkg::CHG_BIT]    = chg_flag_q;
            rdata_d[iopb_pkg::CHG_IE_BIT] = chg_ie_q;
         end
         iopb_pkg::OFS_APC:    rdata_d[5:0] = apc_q;
         iopb_pkg::OFS_STAT:   rdata_d[iopb_pkg::NEV-1:0] = stat_q;
         iopb_pkg::OFS_IEN:    rdata_d[iopb_pkg::NEV-1:0] = ien_q;
         default:              rdata_d = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= '0;
      end else if (setup && !pwrite) begin
         rdata_q <= rdata_d;
      end
   end

   assign prdata = rdata_q;

   // ======================================================
   // checks

   chk_dir_drives_pin: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pin_oe == ~dir_q) && ((pin_out & pin_oe) == (latch_q & pin_oe)))
      else $error("pin drive does not follow direction and latch");

   chk_pullup_output_off: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pullup_en & ~dir_q) == '0)
      else $error("pull-up on while pin is an output");

   chk_pullup_control: assert property (
      @(posedge pclk) disable iff (!presetn)
      $fell(pud_n_q) |-> (pullup_en == dir_q))
      else $error("cleared control did not enable input pull-ups");

   chk_reset_pullup_off: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (pullup_en == '0))
      else $error("pull-ups enabled after reset");

   chk_analog_reads_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      (low_pins_analog(apc_q.sel) && setup && !pwrite &&
       paddr == iopb_pkg::OFS_PORT) |=> (prdata[4:0] == 5'h00))
      else $error("analog pin read as nonzero");

   chk_strap_select: assert property (
      @(posedge pclk) disable iff (!presetn)
      (init_q == iopb_pkg::INIT_SYNC2) |=>
      (apc_q.sel == ($past(strap_s2_q) ? 4'h0 : 4'h7)))
      else $error("select not loaded from strap");

   chk_mismatch_sets: assert property (
      @(posedge pclk) disable iff (!presetn)
      mismatch |=> chg_flag_q && stat_q[iopb_pkg::EV_CHG])
      else $error("mismatch did not set change flag");

   chk_touch_ends: assert property (
      @(posedge pclk) disable iff (!presetn)
      (port_touch && init_q == iopb_pkg::INIT_RUN) |=>
      (ref_q == $past(ioc_live)))
      else $error("port access did not refresh reference");

   chk_output_excluded: assert property (
      @(posedge pclk) disable iff (!presetn)
      (dir_q[W-1:iopb_pkg::IOC_LO] == 4'h0) |-> !mismatch)
      else $error("output pin caused a change");

   chk_wake_level: assert property (
      @(posedge pclk) disable iff (!presetn)
      (mismatch && chg_ie_q && !(psel && paddr == iopb_pkg::OFS_ICTL)) |=> wake_req [*2])
      else $error("change with enable did not wake");

   chk_chan_top: assert property (
      @(posedge pclk) disable iff (!presetn)
      (apc_q.sel == 4'hF) |-> (chan_digital == 11'h7FF))
      else $error("top select left a channel analog");

   chk_ref_select: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == iopb_pkg::OFS_APC && init_q == iopb_pkg::INIT_RUN) |=>
      (neg_ref_ext == $past(pwdata[5])) && (pos_ref_ext == $past(pwdata[4])))
      else $error("reference select not applied");

endmodule : iopb_port

/* tb/iopb_board.sv */
// iopb_board: board model of keys and wires on the eight port pins
`timescale 1ns/1ps
module iopb_board (
   input  wire logic       pclk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pullup_en,
   input  wire logic [7:0] key_val,
   input  wire logic [7:0] key_en,
   output logic      [7:0] pin_lvl
);
   // ======================================
   // wire history, so a floating pin never repeats its old level
   logic [7:0] last_q;
   initial last_q = 8'h00;
   always @(posedge pclk) begin
      last_q <= pin_lvl;
   end
   // device driver beats the keys (they sit behind resistors), then keys,
   // then weak pull-up, else the floating pin wanders
   assign pin_lvl = (pin_oe & pin_out)
                  | (~pin_oe & key_en & key_val)
                  | (~pin_oe & ~key_en & pullup_en)
                  | (~pin_oe & ~key_en & ~pullup_en & ~last_q);
endmodule : iopb_board

/* tb/tb.sv */
// tb: self-checking bench of the port-b block over apb
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); \
   end end
module tb;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } iopb_row_t;
   // ======================================
   // signals
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        strap, neg_ref_ext, pos_ref_ext, wake_req, irq, rerr;
   logic [7:0]  paddr, pin_lvl, pin_out, pin_oe, pullup_en, key_val, key_en;
   logic [31:0] pwdata, prdata, rdat;
   logic [10:0] chan_digital;
   int          n_errors, cmp_count;
   iopb_row_t   rows [5];
   // ======================================
   // design and board
   iopb_port iopb_port_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_lvl), .pin_out(pin_out),
      .pin_oe(pin_oe), .pullup_en(pullup_en), .analog_default_cfg(strap),
      .chan_digital(chan_digital), .neg_ref_ext(neg_ref_ext),
      .pos_ref_ext(pos_ref_ext), .wake_req(wake_req), .irq(irq));
   iopb_board iopb_board_inst (
      .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
      .key_val(key_val), .key_en(key_en), .pin_lvl(pin_lvl));
   // ======================================
   // clock and helpers
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task report_and_stop;
      if (n_errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // one apb transfer; request held until pready is seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) n_errors++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : xfer
   // let the edge's updates land before looking
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : wt
   task automatic do_reset(input logic s);
      presetn <= 1'b0;
      strap <= s;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      wt(3);
   endtask : do_reset
   function automatic logic [10:0] exp_dig(input logic [3:0] s);
      return (s <= 4'h4) ? 11'h000 : 11'h7FF << (4'hF - s);
   endfunction : exp_dig
   // hang guard, far beyond the few hundred cycles needed
   initial begin
      repeat (5000) @(posedge pclk);
      n_errors++;
      report_and_stop();
   end
   // ======================================
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {key_val, key_en, strap} = {8'hFF, 8'hFF, 1'b1};
      n_errors = 0;
      cmp_count = 0;
      rows[0] = '{iopb_pkg::OFS_LATCH, 32'h000000A5, 32'h000000A5};
      rows[1] = '{iopb_pkg::OFS_DIR, 32'h0000005C, 32'h0000005C};
      rows[2] = '{iopb_pkg::OFS_ICTL2, 32'h00000080, 32'h00000080};
      rows[3] = '{iopb_pkg::OFS_APC, 32'h000000FF, 32'h0000003F};
      rows[4] = '{iopb_pkg::OFS_CLR, 32'h00000000, 32'h00000000};
      do_reset(1'b1);
      `CHK(pullup_en, 8'h00)
      `CHK(pin_oe, 8'h00)
      xfer(0, iopb_pkg::OFS_APC, 0);
      `CHK(rdat[3:0], iopb_pkg::SEL_ANALOG)
      xfer(0, iopb_pkg::OFS_PORT, 0);
      `CHK(rdat[7:0], 8'hE0)
      do_reset(1'b0);
      xfer(0, iopb_pkg::OFS_APC, 0);
      `CHK(rdat[3:0], iopb_pkg::SEL_DIGIT)
      xfer(0, iopb_pkg::OFS_PORT, 0);
      `CHK(rdat[7:0], 8'hFF)
      // plain register write and read-back
      foreach (rows[i]) begin
         xfer(1, rows[i].a, rows[i].d);
         xfer(0, rows[i].a, 0);
         `CHK(rdat, rows[i].e)
      end
      // every select code, reference bits walked alongside
      for (int s = 0; s < 16; s++) begin
         xfer(1, iopb_pkg::OFS_APC, {26'h0, s[1:0], s[3:0]});
         `CHK(chan_digital, exp_dig(s[3:0]))
         `CHK({neg_ref_ext, pos_ref_ext}, s[1:0])
      end
      xfer(1, iopb_pkg::OFS_APC, 32'h00000007);
      // mixed directions with pull-ups on, keys let go
      xfer(1, iopb_pkg::OFS_ICTL2, 0);
      xfer(1, iopb_pkg::OFS_DIR, 32'h0000000F);
      xfer(1, iopb_pkg::OFS_LATCH, 32'h000000A0);
      key_en <= 8'h00;
      `CHK(pullup_en, 8'h0F)
      `CHK(pin_oe, 8'hF0)
      wt(3);
      xfer(0, iopb_pkg::OFS_PORT, 0);
      `CHK(rdat[7:0], 8'hAF)
      key_en <= 8'hFF;
      xfer(1, iopb_pkg::OFS_ICTL2, 32'h00000080);
      `CHK(pullup_en, 8'h00)
      // change detection: pin7 is an output, pin3 outside the group
      xfer(1, iopb_pkg::OFS_DIR, 32'h0000007F);
      xfer(1, iopb_pkg::OFS_LATCH, 32'h00000080);
      wt(3);
      xfer(0, iopb_pkg::OFS_PORT, 0);
      xfer(1, iopb_pkg::OFS_IEN, 32'h00000001);
      xfer(1, iopb_pkg::OFS_ICTL, 32'h00000008);
      xfer(1, iopb_pkg::OFS_CLR, 32'h00000003);
      xfer(1, iopb_pkg::OFS_LATCH, 32'h00000000);
      key_val <= 8'hF7;
      wt(4);
      `CHK(irq, 1'b0)
      key_val <= 8'hB7;
      wt(4);
      `CHK(irq, 1'b1)
      `CHK(wake_req, 1'b1)
      xfer(0, iopb_pkg::OFS_STAT, 0); // status, not the port, is watched
      `CHK(rdat[0], 1'b1)
      // clearing without a port read or write does not stick
      xfer(1, iopb_pkg::OFS_ICTL, 32'h00000008);
      wt(2);
      xfer(0, iopb_pkg::OFS_ICTL, 0);
      `CHK(rdat[0], 1'b1)
      xfer(1, iopb_pkg::OFS_PNOREF, 0);
      xfer(1, iopb_pkg::OFS_ICTL, 32'h00000008);
      wt(2);
      xfer(0, iopb_pkg::OFS_ICTL, 0);
      `CHK(rdat[0], 1'b1)
      xfer(1, iopb_pkg::OFS_PORT, 0);
      wt(2);
      xfer(1, iopb_pkg::OFS_ICTL, 32'h00000008);
      xfer(1, iopb_pkg::OFS_CLR, 32'h00000003);
      wt(2);
      xfer(0, iopb_pkg::OFS_ICTL, 0);
      `CHK(rdat[0], 1'b0)
      `CHK({irq, wake_req}, 2'b00)
      // unmapped offset answers with an error and zero
      xfer(0, 8'h30, 0);
      `CHK({rerr, rdat}, {1'b1, 32'h00000000})
      report_and_stop();
   end
endmodule : tb
